// *** rtl/sseirq_top.v ***
/*
  Supply switchover decision and supply event interrupt logic.
  Holds the APB register file, the rail source state machine, event
  flags and the shared interrupt request.
  Assumes comparator and pin inputs already synchronous to pclk, and a
  sag detector that flags each line cycle spent below the threshold.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sseirq_map.vh"

module sseirq_top #(
  parameter integer ADDR_W        = 12,
  parameter integer T_RESTORE_CYC = `SSE_CYC_RESTORE,
  parameter integer T_DC_CYC      = `SSE_CYC_DC_SWITCH,
  parameter integer LONG_W        = 25
) (
  // clock and reset
  input  wire              pclk,
  input  wire              presetn,
  // apb slave
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [ADDR_W-1:0] paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output reg               pready,
  output reg               pslverr,
  // supply comparators, high while above threshold
  input  wire              main_supply_ok,
  input  wire              dc_monitor_input_ok,
  // sag detector
  input  wire              sag_below,
  input  wire              line_cycle_tick,
  // external force pin
  input  wire              battery_force_pin,
  // rail switch and core interrupt
  output wire              switched_rail_on_main,
  output reg               supply_irq_r
);

  localparam [1:0] ST_MAIN = 2'h1;
  localparam [1:0] ST_BATT = 2'h2;
  localparam integer ST_MAIN_B = 0;

  // software visible state
  reg  [7:0] irq_en_prio_r;
  reg  [7:0] evt_en_r;
  reg  [1:0] src_sel_r;
  reg  [1:0] pin_cfg_r;
  reg  [7:0] sag_cyc_r;

  // rail state and helpers
  reg  [1:0] st_r;
  reg  [1:0] st_nxt;
  reg        force_prev_r;
  reg  [7:0] sag_cnt_r;
  reg        sag_done_r;

  // register bus decode
  reg  [31:0] rd_data;
  reg         hit;
  wire [7:0]  idx;
  wire        high_ok;
  wire        access;
  wire        commit;
  wire        wr;

  // event wiring
  reg  [7:0] flag_set;
  wire [7:0] flag_clr;
  wire [7:0] flag_q;
  wire [7:0] flag_rd;
  wire       pending;

  // qualified conditions
  wire main_low_q;
  wire dc_low_q;
  wire dc_long_q;
  wire restore_q;

  // decoded control
  wire swo_dis;
  wire main_trig_en;
  wire dc_trig_en;
  wire pin_en;
  wire force_fall;
  wire restore_cond;
  wire go_batt;
  wire ev_to_batt;
  wire ev_restore;
  wire sag_hit;

  //--------------------------------------------------------------
  // configuration decode
  //--------------------------------------------------------------

  // bit 1 of the select field doubles as the disable
  assign swo_dis      = src_sel_r[`SSE_BIT_SWO_DIS];      // RULE17
  assign main_trig_en = !swo_dis;                         // RULE16
  assign dc_trig_en   = (src_sel_r == `SSE_SEL_DC);       // RULE16
  assign pin_en       = (pin_cfg_r == `SSE_PIN_FORCE);

  // force pin edge, reset high so release is no false edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      force_prev_r <= 1'b1;
    end else begin
      force_prev_r <= battery_force_pin;
    end
  end

  assign force_fall = pin_en && force_prev_r && !battery_force_pin; // RULE18

  //--------------------------------------------------------------
  // comparator qualification
  //--------------------------------------------------------------

  // short filter keeps a glitch from switching the rail
  sseirq_qual #(
    .CYCLES (`SSE_CYC_MIN),
    .CNT_W  (2)
  ) u_main_low (
    .pclk    (pclk),
    .presetn (presetn),
    .cond    (!main_supply_ok),
    .held    (main_low_q)
  ); // RULE14

  // same floor delay for the dc-low flag
  sseirq_qual #(
    .CYCLES (`SSE_CYC_MIN),
    .CNT_W  (2)
  ) u_dc_low (
    .pclk    (pclk),
    .presetn (presetn),
    .cond    (!dc_monitor_input_ok),
    .held    (dc_low_q)
  ); // RULE12

  // dc switchover waits out the long delay
  sseirq_qual #(
    .CYCLES (T_DC_CYC),
    .CNT_W  (LONG_W)
  ) u_dc_long (
    .pclk    (pclk),
    .presetn (presetn),
    .cond    (dc_trig_en && !dc_monitor_input_ok),
    .held    (dc_long_q)
  ); // RULE15

  // restore needs every enabled trigger cleared
  assign restore_cond = (st_r == ST_BATT)
                     && main_supply_ok
                     && (!dc_trig_en || dc_monitor_input_ok)
                     && (!pin_en || battery_force_pin); // RULE1 RULE3

  // a dip during the wait restarts the full delay
  sseirq_qual #(
    .CYCLES (T_RESTORE_CYC),
    .CNT_W  (LONG_W)
  ) u_restore (
    .pclk    (pclk),
    .presetn (presetn),
    .cond    (restore_cond),
    .held    (restore_q)
  ); // RULE2

  //--------------------------------------------------------------
  // rail source state machine
  //--------------------------------------------------------------

  assign go_batt = (main_trig_en && main_low_q)           // RULE14
                || dc_long_q                              // RULE15
                || force_fall;                            // RULE18

  // next state
  always @* begin
    st_nxt = st_r;
    case (st_r)
      ST_MAIN: begin
        if (!swo_dis && go_batt) begin
          st_nxt = ST_BATT;
        end
      end
      ST_BATT: begin
        if (swo_dis || restore_q) begin
          st_nxt = ST_MAIN; // RULE1 RULE17
        end
      end
      default: begin
        st_nxt = ST_MAIN;
      end
    endcase
  end

  // state register, powers up on the main supply
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= ST_MAIN;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign switched_rail_on_main = st_r[ST_MAIN_B];
  assign ev_to_batt = (st_r == ST_MAIN) && (st_nxt == ST_BATT); // RULE7
  assign ev_restore = (st_r == ST_BATT) && (st_nxt == ST_MAIN); // RULE8

  //--------------------------------------------------------------
  // sag persistence counter
  //--------------------------------------------------------------

  // fires once per sag; a recovered line rearms it
  assign sag_hit = line_cycle_tick && sag_below && !sag_done_r
                && ((sag_cnt_r + 8'h01) >= sag_cyc_r);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sag_cnt_r  <= 8'h00;
      sag_done_r <= 1'b0;
    end else if (!sag_below) begin
      sag_cnt_r  <= 8'h00;
      sag_done_r <= 1'b0;
    end else if (line_cycle_tick && !sag_done_r) begin
      sag_cnt_r  <= sag_cnt_r + 8'h01;
      sag_done_r <= sag_hit; // RULE13
    end
  end

  //--------------------------------------------------------------
  // event flags
  //--------------------------------------------------------------

  // set strobes, independent of any enable
  always @* begin
    flag_set = 8'h00;
    flag_set[`SSE_BIT_RESTORE] = ev_restore;  // RULE8 RULE9
    flag_set[`SSE_BIT_TO_BATT] = ev_to_batt;  // RULE7 RULE9
    flag_set[`SSE_BIT_SAG]     = sag_hit;     // RULE13
    flag_set[`SSE_BIT_DC_LOW]  = dc_low_q;    // RULE12
  end

  // only a written zero clears, writing one leaves a flag alone
  assign flag_clr = (wr && idx == `SSE_IDX_EVT_FLAGS)
                  ? ~pwdata[7:0] : 8'h00; // RULE10

  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_flag
      if (((`SSE_EVT_MASK >> i) & 1) != 0) begin : g_imp
        sseirq_flag u_flag (
          .pclk    (pclk),
          .presetn (presetn),
          .set     (flag_set[i]),
          .clr     (flag_clr[i]),
          .flag_r  (flag_q[i])
        ); // RULE6 RULE19
      end else begin : g_rsv
        assign flag_q[i] = 1'b0;
      end
    end
  endgenerate

  // summary bit shows any flag that would request
  assign pending = |(flag_q & evt_en_r);                  // RULE5
  assign flag_rd = flag_q | ({7'h00, pending} << `SSE_BIT_SUMMARY); // RULE19

  // shared request, registered so the output is a flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      supply_irq_r <= 1'b0;
    end else begin
      supply_irq_r <= irq_en_prio_r[`SSE_BIT_GLOBAL_EN] && pending; // RULE20 RULE4
    end
  end

  //--------------------------------------------------------------
  // apb slave
  //--------------------------------------------------------------

  // one wait state buys registered read data
  assign idx     = paddr[9:2];
  assign high_ok = (paddr[ADDR_W-1:10] == {(ADDR_W-10){1'b0}})
                && (paddr[1:0] == 2'h0);
  assign access  = psel && penable;
  assign commit  = access && pready;
  assign wr      = commit && pwrite && hit;

  // read mux and address hit
  always @* begin
    rd_data = 32'h00000000;
    hit     = high_ok;
    if (idx == `SSE_IDX_IRQ_EN_PRIO) begin
      rd_data[7:0] = irq_en_prio_r;
    end else if (idx == `SSE_IDX_EVT_EN) begin
      rd_data[7:0] = evt_en_r;
    end else if (idx == `SSE_IDX_EVT_FLAGS) begin
      rd_data[7:0] = flag_rd;
    end else if (idx == `SSE_IDX_PERIPHERAL_CONFIG_CFG) begin
      rd_data[`SSE_BIT_RAIL_SRC] = switched_rail_on_main; // RULE11
    end else if (idx == `SSE_IDX_SWO_CFG) begin
      rd_data[1:0] = src_sel_r;
    end else if (idx == `SSE_IDX_PIN_CFG) begin
      rd_data[1:0] = pin_cfg_r;
    end else if (idx == `SSE_IDX_SAG_CYC) begin
      rd_data[7:0] = sag_cyc_r;
    end else begin
      hit = 1'b0;
    end
  end

  // handshake: ready on the second access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else if (access && !pready) begin
      pready  <= 1'b1;
      pslverr <= !hit;
      prdata  <= pwrite ? 32'h00000000 : rd_data;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // register writes take effect at the completing edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_prio_r <= `SSE_RST_BYTE;   // RULE4
      evt_en_r      <= `SSE_RST_BYTE;
      src_sel_r     <= 2'h0;            // RULE16
      pin_cfg_r     <= 2'h0;
      sag_cyc_r     <= `SSE_RST_SAG_CYC;
    end else if (wr) begin
      if (idx == `SSE_IDX_IRQ_EN_PRIO) begin
        irq_en_prio_r <= pwdata[7:0] & `SSE_IEP_MASK;
      end else if (idx == `SSE_IDX_EVT_EN) begin
        evt_en_r <= pwdata[7:0] & `SSE_EVT_MASK; // RULE5 RULE19
      end else if (idx == `SSE_IDX_SWO_CFG) begin
        src_sel_r <= pwdata[1:0];
      end else if (idx == `SSE_IDX_PIN_CFG) begin
        pin_cfg_r <= pwdata[1:0];
      end else if (idx == `SSE_IDX_SAG_CYC) begin
        sag_cyc_r <= pwdata[7:0];
      end
    end
  end

endmodule

`default_nettype wire

// *** rtl/sseirq_map.vh ***
/*
  Constants for the supply switchover and supply event interrupt block:
  register indices, field positions, reset values and timing counts.
  Assumes a 200 MHz core clock and an APB slave with one word per index.
*/
// Operation
// RULE1: restore only when all enabled triggers false
// RULE2: restore about 130 ms after conditions hold
// RULE3: force pin must be high to restore
// RULE4: global supply interrupt enable, off at reset
// RULE5: one shared request, event enable selects
// RULE6: flags latched until software writes them
// RULE7: main-to-battery sets to-battery flag
// RULE8: battery-to-main sets restore flag
// RULE9: flags set whatever the enables
// RULE10: writing 0 clears a flag, nothing else
// RULE11: status bit 6 high while on main
// RULE12: dc-low flag at least 10 ns after crossing
// RULE13: sag flag after programmed line cycles below
// RULE14: main-low trigger switches after 10 ns min
// RULE15: dc trigger switches about 30 ms later
// RULE16: select 01 adds dc trigger, default off
// RULE17: config bit 1 disables switchover entirely
// RULE18: force pin falling edge switches to battery
// RULE19: fixed bit positions in enable and flags
// RULE20: request is global AND any enabled flag
`ifndef SSEIRQ_MAP_VH
`define SSEIRQ_MAP_VH

// register indices, byte address is four times the index
`define SSE_IDX_IRQ_EN_PRIO 8'hA9
`define SSE_IDX_EVT_EN      8'hEC
`define SSE_IDX_EVT_FLAGS   8'hF8
`define SSE_IDX_PERIPHERAL_CONFIG_CFG  8'hF4
`define SSE_IDX_SWO_CFG     8'hF5
`define SSE_IDX_PIN_CFG     8'hFF
`define SSE_IDX_SAG_CYC     8'hE0

// field positions
`define SSE_BIT_RESTORE   7
`define SSE_BIT_SUMMARY   6
`define SSE_BIT_SAG       5
`define SSE_BIT_TO_BATT   1
`define SSE_BIT_DC_LOW    0
`define SSE_BIT_GLOBAL_EN 1
`define SSE_BIT_RAIL_SRC  6
`define SSE_BIT_SWO_DIS   1

// implemented bits and reset values
`define SSE_EVT_MASK      8'hA3
`define SSE_IEP_MASK      8'h5F
`define SSE_RST_BYTE      8'h00
`define SSE_RST_SAG_CYC   8'h03
`define SSE_SEL_DC        2'h1
`define SSE_PIN_FORCE     2'h1

// timing, figures in their own units, counts derived
`define SSE_CLK_KHZ        200000
`define SSE_T_RESTORE_MS   130
`define SSE_T_DC_SWITCH_MS 30
`define SSE_T_MIN_NS       10
`define SSE_CYC_RESTORE    (`SSE_T_RESTORE_MS * `SSE_CLK_KHZ)
`define SSE_CYC_DC_SWITCH  (`SSE_T_DC_SWITCH_MS * `SSE_CLK_KHZ)
`define SSE_CYC_MIN        ((`SSE_T_MIN_NS * `SSE_CLK_KHZ + 999999) / 1000000)

`endif

// *** rtl/sseirq_qual.v ***
/*
  Persistence qualifier: output goes high once the condition has held
  for a set number of consecutive clocks, and drops one clock after it
  falls. Assumes a synchronous condition input.
*/
`timescale 1ns/1ps
`default_nettype none

module sseirq_qual #(
  parameter integer CYCLES = 2,
  parameter integer CNT_W  = 2
) (
  // clock and reset
  input  wire pclk,
  input  wire presetn,
  // condition and result
  input  wire cond,
  output wire held
);

  localparam [CNT_W-1:0] LIM  = CYCLES[CNT_W-1:0];
  localparam [CNT_W-1:0] ZERO = {CNT_W{1'b0}};
  localparam [CNT_W-1:0] ONE  = {{(CNT_W-1){1'b0}}, 1'b1};

  reg [CNT_W-1:0] cnt_r;

  // saturating count so a long condition never wraps back to low
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= ZERO;
    end else if (!cond) begin
      cnt_r <= ZERO;
    end else if (cnt_r != LIM) begin
      cnt_r <= cnt_r + ONE;
    end
  end

  assign held = (cnt_r == LIM);

endmodule

`default_nettype wire

// *** rtl/sseirq_flag.v ***
/*
  Sticky event flag: set by hardware, cleared by software.
  Assumes set and clear are synchronous one-clock strobes.
*/
`timescale 1ns/1ps
`default_nettype none

module sseirq_flag (
  // clock and reset
  input  wire pclk,
  input  wire presetn,
  // set and clear strobes
  input  wire set,
  input  wire clr,
  // latched state
  output reg  flag_r
);

  // set beats clear so an event in the clearing cycle survives
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_r <= 1'b0;
    end else if (set) begin
      flag_r <= 1'b1;
    end else if (clr) begin
      flag_r <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// *** tb/sseirq_assertions.sv ***
/*
  Port-level properties of sseirq_top, bound into it.
  Assumes APB writes commit at the edge where pready is sampled high.
*/
`timescale 1ns/1ps
`default_nettype none
module sseirq_assertions #(
  parameter integer ADDR_W = 12
) (
  // clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  // apb
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // supply side
  input wire logic              main_supply_ok,
  input wire logic              battery_force_pin,
  input wire logic              switched_rail_on_main,
  input wire logic              supply_irq_r
);
  logic       gen_r;
  logic [7:0] en_r;
  logic [1:0] cfg_r;
  logic [1:0] pin_r;
  wire        wr_ok = psel && penable && pready && pwrite && !pslverr;

  // shadows of the control bits, since the checker sees no registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gen_r <= 1'b0;
      en_r  <= 8'h00;
      cfg_r <= 2'h0;
      pin_r <= 2'h0;
    end else if (wr_ok) begin
      if (paddr == 12'h2A4) gen_r <= pwdata[1];
      if (paddr == 12'h3B0) en_r <= pwdata[7:0] & 8'hA3;
      if (paddr == 12'h3D4) cfg_r <= pwdata[1:0];
      if (paddr == 12'h3FC) pin_r <= pwdata[1:0];
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // apb setup then access phase
  sequence s_setup_access;
    psel && !penable ##1 psel && penable;
  endsequence
  // main supply low long enough to pass the qualifier, switchover allowed
  sequence s_main_low;
    (!main_supply_ok && !cfg_r[1]) [*5];
  endsequence

  a_reset_state: assert property ($rose(presetn) |-> switched_rail_on_main && !supply_irq_r)
    else $error("rail or request wrong after reset");
  a_apb_ready: assert property (s_setup_access |=> pready)
    else $error("no pready in second access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_irq_needs_enable: assert property (supply_irq_r |-> $past(gen_r) && $past(en_r) != 8'h00)
    else $error("request without global and event enable");
  a_main_low: assert property (s_main_low |-> !switched_rail_on_main)
    else $error("no switchover on low main supply");
  a_to_batt_irq: assert property ($fell(switched_rail_on_main) && gen_r && en_r[1] |-> ##[0:2] supply_irq_r)
    else $error("no request after switchover");
  a_restore_irq: assert property ($rose(switched_rail_on_main) && gen_r && en_r[7] |-> ##[0:2] supply_irq_r)
    else $error("no request after restore");
  a_force_pin: assert property (pin_r == 2'h1 && !cfg_r[1] && $fell(battery_force_pin) |-> ##[1:3] !switched_rail_on_main)
    else $error("force pin fall did not switch");
  a_disable_holds: assert property (cfg_r[1] [*3] |-> switched_rail_on_main)
    else $error("rail left main while disabled");
endmodule

bind sseirq_top sseirq_assertions #(.ADDR_W(ADDR_W)) i_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
  .main_supply_ok, .battery_force_pin, .switched_rail_on_main, .supply_irq_r
);
`default_nettype wire

// *** tb/sseirq_supply_model.sv ***
/*
  Far-side model: supply comparators, sag detector and force pin.
  Assumes the bench sets the analog levels; outputs change on the clock.
*/
`timescale 1ns/1ps
`default_nettype none
module sseirq_supply_model #(
  parameter int TICK_DIV = 8
) (
  // clock
  input  wire logic pclk,
  // levels asked for by the bench
  input  wire logic main_lvl,
  input  wire logic dc_lvl,
  input  wire logic sag_lvl,
  input  wire logic pin_lvl,
  // comparator, detector and pin outputs
  output var  logic main_supply_ok,
  output var  logic dc_monitor_input_ok,
  output var  logic sag_below,
  output var  logic line_cycle_tick,
  output var  logic battery_force_pin
);
  logic [7:0] div_r = 8'h00;

  // supplies good, pin high and no sag until the bench says otherwise
  initial {main_supply_ok, dc_monitor_input_ok, battery_force_pin, sag_below} = 4'hE;
  initial line_cycle_tick = 1'b0;

  // comparators resolve on the clock, as the design has no synchroniser
  always @(posedge pclk) begin
    main_supply_ok      <= main_lvl;
    dc_monitor_input_ok <= dc_lvl;
    sag_below           <= sag_lvl;
    battery_force_pin   <= pin_lvl;
  end

  // one tick per line cycle; a short line cycle keeps sag runs brief
  always @(posedge pclk) begin
    div_r           <= (div_r == TICK_DIV - 1) ? 8'h00 : div_r + 8'h01;
    line_cycle_tick <= (div_r == 8'h00);
  end
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
/*
  Self-checking bench for sseirq_top with the supply model on its far side.
  Assumes rtl/ on the include path; restore and dc delays are shortened.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sseirq_map.vh"
module testbench;
  localparam int         T_RST  = 20;
  localparam int         T_DC   = 10;
  localparam logic [7:0] ix_iep = `SSE_IDX_IRQ_EN_PRIO;
  localparam logic [7:0] ix_en  = `SSE_IDX_EVT_EN;
  localparam logic [7:0] ix_flg = `SSE_IDX_EVT_FLAGS;
  localparam logic [7:0] ix_swo = `SSE_IDX_SWO_CFG;
  localparam logic [7:0] ix_pin = `SSE_IDX_PIN_CFG;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, d;
  logic        pready, pslverr, err, supply_irq_r, switched_rail_on_main;
  logic        main_lvl = 1'b1, dc_lvl = 1'b1, sag_lvl = 1'b0, pin_lvl = 1'b1;
  logic        main_supply_ok, dc_monitor_input_ok, sag_below, line_cycle_tick;
  logic        battery_force_pin;
  int          n_mismatch = 0, tests_run = 0, cyc = 0, n, k;

  sseirq_top #(.T_RESTORE_CYC(T_RST), .T_DC_CYC(T_DC)) i_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .main_supply_ok, .dc_monitor_input_ok, .sag_below, .line_cycle_tick,
    .battery_force_pin, .switched_rail_on_main, .supply_irq_r
  );
  sseirq_supply_model #(.TICK_DIV(8)) i_far (
    .pclk, .main_lvl, .dc_lvl, .sag_lvl, .pin_lvl, .main_supply_ok,
    .dc_monitor_input_ok, .sag_below, .line_cycle_tick, .battery_force_pin
  );

  // 200 MHz clock and a hang guard far above the expected run
  always #2.5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 6000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  function automatic logic in_rng(int v, int lo, int hi);
    return v >= lo && v <= hi;
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    tests_run++;
    if (seen !== ex) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, ex, seen);
    end
  endtask

  // one apb transfer; the request is held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] ix, input logic [31:0] wd);
    apb(1'b1, {2'b00, ix, 2'b00}, wd);
  endtask

  task automatic rdchk(input string nm, input logic [7:0] ix, input logic [31:0] ex);
    apb(1'b0, {2'b00, ix, 2'b00}, 32'h0);
    chk(nm, rd, ex);
  endtask

  // counts edges until the rail reaches v, bounded
  task automatic wait_rail(input logic v);
    n = 0;
    while (switched_rail_on_main !== v && n < 200) begin
      @(posedge pclk);
      n++;
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    k = $urandom(32'h1BFB8E76);
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, then an unmapped word
    rdchk("iep", ix_iep, 32'h0);
    rdchk("evt_en", ix_en, 32'h0);
    rdchk("flags", ix_flg, 32'h0);
    rdchk("status", `SSE_IDX_PERIPHERAL_CONFIG_CFG, 32'h40);
    rdchk("sag_cyc", `SSE_IDX_SAG_CYC, `SSE_RST_SAG_CYC);
    apb(1'b0, 12'h004, 32'h0);
    chk("slverr", err, 32'h1);
    // random patterns; reserved bits read back as zero
    repeat (4) begin
      d = $urandom;
      wr(ix_en, d);
      rdchk("evt_en", ix_en, d & `SSE_EVT_MASK);
      wr(ix_iep, d);
      rdchk("iep", ix_iep, d & `SSE_IEP_MASK);
    end
    wr(ix_en, 32'h0);
    wr(ix_iep, 32'h0);
    // main drop with enables clear: flag latches, no request
    main_lvl <= 1'b0;
    wait_rail(1'b0);
    chk("to_batt_dly", in_rng(n, 3, 7), 32'h1);
    rdchk("flags", ix_flg, 32'h02);
    rdchk("status", `SSE_IDX_PERIPHERAL_CONFIG_CFG, 32'h0);
    chk("irq", supply_irq_r, 32'h0);
    wr(ix_en, 32'h02);
    wr(ix_iep, 32'h02);
    repeat (2) @(posedge pclk);
    chk("irq", supply_irq_r, 32'h1);
    rdchk("flags", ix_flg, 32'h42);
    wr(ix_flg, 32'hFD);
    rdchk("flags", ix_flg, 32'h0);
    chk("irq", supply_irq_r, 32'h0);
    // restore, with a one-cycle dropout that restarts the delay
    wr(ix_en, 32'h82);
    main_lvl <= 1'b1;
    repeat (8) @(posedge pclk);
    main_lvl <= 1'b0;
    @(posedge pclk);
    main_lvl <= 1'b1;
    wait_rail(1'b1);
    chk("restore_dly", in_rng(n, T_RST, T_RST + 6), 32'h1);
    rdchk("flags", ix_flg, 32'hC0);
    wr(ix_flg, 32'h0);
    // dc trigger; restore waits for the dc input as well
    wr(ix_swo, 32'h1);
    dc_lvl <= 1'b0;
    wait_rail(1'b0);
    chk("dc_dly", in_rng(n, T_DC, T_DC + 5), 32'h1);
    rdchk("flags", ix_flg, 32'h43);
    repeat (40) @(posedge pclk);
    chk("rail", switched_rail_on_main, 32'h0);
    dc_lvl <= 1'b1;
    wait_rail(1'b1);
    chk("restore_dly", in_rng(n, T_RST, T_RST + 6), 32'h1);
    wr(ix_swo, 32'h0);
    wr(ix_flg, 32'h0);
    // force pin: fall switches, restore only once it is high again
    wr(ix_pin, 32'h1);
    pin_lvl <= 1'b0;
    wait_rail(1'b0);
    chk("pin_dly", in_rng(n, 1, 5), 32'h1);
    repeat (40) @(posedge pclk);
    chk("rail", switched_rail_on_main, 32'h0);
    pin_lvl <= 1'b1;
    wait_rail(1'b1);
    chk("restore_dly", in_rng(n, T_RST, T_RST + 6), 32'h1);
    wr(ix_pin, 32'h0);
    wr(ix_flg, 32'h0);
    // switchover disabled: main drop is ignored
    wr(ix_swo, 32'h2);
    main_lvl <= 1'b0;
    repeat (40) @(posedge pclk);
    chk("rail", switched_rail_on_main, 32'h1);
    rdchk("flags", ix_flg, 32'h0);
    main_lvl <= 1'b1;
    wr(ix_swo, 32'h0);
    // sag over a random count of line cycles
    k = 2 + $urandom_range(2);
    wr(`SSE_IDX_SAG_CYC, k);
    wr(ix_en, 32'h20);
    @(posedge line_cycle_tick);
    sag_lvl <= 1'b1;
    repeat (k - 1) @(posedge line_cycle_tick);
    rdchk("flags", ix_flg, 32'h0);
    @(posedge line_cycle_tick);
    repeat (3) @(posedge pclk);
    rdchk("flags", ix_flg, 32'h60);
    sag_lvl <= 1'b0;
    give_verdict();
  end
endmodule
`default_nettype wire
